// File: acsp_consts.svh
// opcode, subcommand, attribute and timing constants of the command and power unit
`ifndef ACSP_CONSTS_SVH
`define ACSP_CONSTS_SVH
`define ACSP_OP_CHK_PWR 8'hE5
`define ACSP_OP_IDLE_IMM 8'hE1
`define ACSP_OP_STBY_IMM 8'hE0
`define ACSP_OP_NCQ_RD 8'h60
`define ACSP_OP_NCQ_WR 8'h61
`define ACSP_OP_ERASE_PREP 8'hF3
`define ACSP_OP_ERASE_UNIT 8'hF4
`define ACSP_OP_HEALTH 8'hB0
`define ACSP_OP_TRIM 8'h06
`define ACSP_SUB_RD_DATA 8'hD0
`define ACSP_SUB_RD_THR 8'hD1
`define ACSP_SUB_AUTOSAVE 8'hD2
`define ACSP_SUB_OFFLINE 8'hD4
`define ACSP_SUB_ENABLE 8'hD8
`define ACSP_SUB_DISABLE 8'hD9
`define ACSP_SUB_STATUS 8'hDA
`define ACSP_AUTOSAVE_ON 8'hF1
`define ACSP_ATTR_POH 8'h09
`define ACSP_ATTR_PCYC 8'h0C
`define ACSP_ATTR_ERS_MAX 8'hA3
`define ACSP_ATTR_ERS_AVG 8'hA4
`define ACSP_ATTR_BAD_LATER 8'hA6
`define ACSP_ATTR_PHY_ERR 8'hA8
`define ACSP_ATTR_UPL 8'hC0
`define ACSP_ATTR_TEMP 8'hC2
`define ACSP_ATTR_SECT_WR 8'hF1
`define ACSP_NUM_ATTR 9
`define ACSP_REC_BYTES 12
`define ACSP_REC_ID 0
`define ACSP_REC_FLAG_LO 1
`define ACSP_REC_FLAG_HI 2
`define ACSP_REC_VALUE 3
`define ACSP_REC_WORST 4
`define ACSP_REC_RAW0 5
`define ACSP_ATTR_FLAGS 16'h0032
`define ACSP_ATTR_NORM 8'h64
`define ACSP_ECC_MAX_BITS 8'h48
`define ACSP_ST_OK 8'h50
`define ACSP_ST_ERR 8'h51
`define ACSP_ER_ABORT 8'h04
`define ACSP_PM_ACTIVE 8'hFF
`define ACSP_PM_IDLE 8'h80
`define ACSP_PM_STBY 8'h00
`define ACSP_CLK_MHZ 50
`define ACSP_PARTIAL_WAKE_NS 10000
`define ACSP_SLUMBER_WAKE_US 10000
`define ACSP_DEVSLP_EXIT_US 20000
`define ACSP_PARTIAL_WAKE_CYC ((`ACSP_PARTIAL_WAKE_NS * `ACSP_CLK_MHZ) / 1000 - 1)
`define ACSP_SLUMBER_WAKE_CYC (`ACSP_SLUMBER_WAKE_US * `ACSP_CLK_MHZ - 1)
`define ACSP_DEVSLP_EXIT_CYC (`ACSP_DEVSLP_EXIT_US * `ACSP_CLK_MHZ - 1)
`endif

// File: acsp_host_model.sv
// host controller model: issues commands, power requests and the sleep pin
`timescale 1ns/1ns
module acsp_host_model #(
	parameter int SLEEP_MAX_CYC = 500000
) (
	input wire logic clk_sys,
	input wire logic cmd_ready,
	input wire logic cmd_done,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_byte,
	input wire logic rsp_last,
	output logic cmd_valid,
	output logic [7:0] cmd_opcode,
	output logic [7:0] cmd_feature,
	output logic [7:0] cmd_count,
	output logic host_lp_req,
	output logic host_lp_slumber,
	output logic host_wake,
	output logic devslp_pin
);
	logic [7:0] rsp_buf [128];
	int n_rsp;
	int last_at;
	int slp_cyc = 0;
	logic tmo = 1'b0;
	initial begin
		{cmd_valid, host_lp_req, host_lp_slumber, host_wake, devslp_pin} = 5'h00;
		{cmd_opcode, cmd_feature, cmd_count} = 24'h00_0000;
	end
	// the host never holds sleep past its limit, so the pin drops by itself
	always @(posedge clk_sys) begin
		slp_cyc <= devslp_pin ? slp_cyc + 1 : 0;
		if (slp_cyc >= SLEEP_MAX_CYC) devslp_pin <= 1'b0;
	end
	// request held until ready is seen at an edge; released lines show inverted data
	task automatic send(input logic [7:0] op, input logic [7:0] ft, input logic [7:0] cn);
		int i;
		n_rsp = 0;
		last_at = -1;
		i = 0;
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		{cmd_opcode, cmd_feature, cmd_count} <= {op, ft, cn};
		do begin
			@(posedge clk_sys);
			i++;
		end while (cmd_ready !== 1'b1 && i < 2000);
		cmd_valid <= 1'b0;
		{cmd_opcode, cmd_feature, cmd_count} <= ~{op, ft, cn};
		// gather answer bytes until the closing pulse
		while (cmd_done !== 1'b1 && i < 2000) begin
			@(posedge clk_sys);
			i++;
			if (rsp_valid === 1'b1 && n_rsp < 128) rsp_buf[n_rsp++] = rsp_byte;
			if (rsp_last === 1'b1) last_at = n_rsp - 1;
		end
		tmo = (i >= 2000);
	endtask
	// one-cycle low-power request (w low) or wake pulse (w high)
	task automatic req(input logic w, input logic s);
		@(posedge clk_sys);
		host_lp_req <= ~w;
		host_wake <= w;
		host_lp_slumber <= s;
		@(posedge clk_sys);
		{host_lp_req, host_wake} <= 2'b00;
	endtask
	task automatic sleep_pin(input logic v);
		@(posedge clk_sys);
		devslp_pin <= v;
	endtask
endmodule

// File: acsp_pkg.sv
// types of the command and power unit
package acsp_pkg;
	typedef enum logic [1:0] {
		ACSP_CS_IDLE = 2'b00,
		ACSP_CS_STREAM = 2'b01,
		ACSP_CS_DONE = 2'b10
	} acsp_cmd_e;
	typedef enum logic [2:0] {
		ACSP_LS_ACTIVE = 3'b000,
		ACSP_LS_PARTIAL = 3'b001,
		ACSP_LS_SLUMBER = 3'b010,
		ACSP_LS_DEVSLP = 3'b011,
		ACSP_LS_WAKE = 3'b100
	} acsp_link_e;
	typedef enum logic [1:0] {
		ACSP_PM_ACT = 2'b00,
		ACSP_PM_IDL = 2'b01,
		ACSP_PM_STB = 2'b10
	} acsp_pmode_e;
endpackage

// File: acsp_rec_fmt.sv
// formatter of one byte of a 12-byte attribute or threshold record
`timescale 1ns/1ns
`include "acsp_consts.svh"
module acsp_rec_fmt
	import acsp_pkg::*;
#(
	parameter logic [7:0] THRESHOLD = 8'h00
) (
	acsp_rec_if.fmt rec
);
	// attribute id for each record slot, in reporting order
	function automatic logic [7:0] acsp_attr_id(input logic [3:0] idx);
		unique case (idx)
			4'h0: acsp_attr_id = `ACSP_ATTR_POH;
			4'h1: acsp_attr_id = `ACSP_ATTR_PCYC;
			4'h2: acsp_attr_id = `ACSP_ATTR_ERS_MAX;
			4'h3: acsp_attr_id = `ACSP_ATTR_ERS_AVG;
			4'h4: acsp_attr_id = `ACSP_ATTR_BAD_LATER;
			4'h5: acsp_attr_id = `ACSP_ATTR_PHY_ERR;
			4'h6: acsp_attr_id = `ACSP_ATTR_UPL;
			4'h7: acsp_attr_id = `ACSP_ATTR_TEMP;
			4'h8: acsp_attr_id = `ACSP_ATTR_SECT_WR;
			default: acsp_attr_id = 8'h00;
		endcase
	endfunction

	logic [7:0] flags_b;
	logic [3:0] raw_b;
	assign flags_b = 8'((rec.byte_idx == 4'(`ACSP_REC_FLAG_LO)) ? `ACSP_ATTR_FLAGS : `ACSP_ATTR_FLAGS >> 8);
	assign raw_b = rec.byte_idx - 4'(`ACSP_REC_RAW0);

	// byte layout: id, flags, value, worst, raw lsb first; threshold records carry id and threshold
	always_comb begin
		if (rec.byte_idx == 4'(`ACSP_REC_ID)) begin
			rec.rec_byte = acsp_attr_id(rec.attr_idx);
		end else if (rec.thr_sel) begin
			rec.rec_byte = (rec.byte_idx == 4'(`ACSP_REC_FLAG_LO)) ? THRESHOLD : 8'h00;
		end else if (rec.byte_idx <= 4'(`ACSP_REC_FLAG_HI)) begin
			rec.rec_byte = flags_b;
		end else if (rec.byte_idx <= 4'(`ACSP_REC_WORST)) begin
			rec.rec_byte = `ACSP_ATTR_NORM;
		end else if (rec.byte_idx < 4'(`ACSP_REC_BYTES)) begin
			rec.rec_byte = rec.raw[{raw_b[2:0], 3'b000} +: 8];
		end else begin
			rec.rec_byte = 8'h00;
		end
	end
endmodule

// File: acsp_rec_if.sv
// attribute record request and byte answer between the unit and its record formatter
`timescale 1ns/1ns
interface acsp_rec_if;
	logic [3:0] attr_idx;
	logic [3:0] byte_idx;
	logic thr_sel;
	logic [55:0] raw;
	logic [7:0] rec_byte;
	modport fmt (input attr_idx, input byte_idx, input thr_sel, input raw, output rec_byte);
	modport user (output attr_idx, output byte_idx, output thr_sel, output raw, input rec_byte);
endinterface

// File: acsp_unit.sv
// command decoder, health reporting, link power sequencer and flash duty control
`timescale 1ns/1ns
`include "acsp_consts.svh"
// Notes on behaviour
// - flash units of 1K bytes correct up to 72 bad bits, else flag failure.
// - a bad block has its contents moved to a free block with correction.
// - on supply loss, run several program cycles saving mapping metadata.
// - after power-up, rebuild mapping and rescan programmed blocks before accepting commands.
// - trim command discards the named data and reclaims the space.
// - wake from partial takes fewer than 10 us.
// - wake from slumber takes fewer than 10 ms.
// - with auto slumber on, partial moves straight to slumber.
// - host may request low power; device requests its own when enabled.
// - after the sleep pin drops, leave device sleep within 20 ms.
// - when fitted, the sleep pin powers the PHY down into device sleep.
// - E5h reports power mode; E1h enters idle, E0h enters standby.
// - 60h is a queued read, 61h a queued write.
// - F3h prepares erase, F4h then wipes all user data.
// - B0h is the health command, dispatched on its subcommand.
// - subcommand D0h returns attributes, D1h thresholds, DAh health status.
// - D2h sets autosave, D4h starts off-line collection, D8h/D9h toggle monitoring.
// - record is id, two flag bytes, value, worst, seven raw bytes lsb first.
// - attributes 09h power-on hours, 0Ch power cycles, C0h power losses.
// - attributes A3h max erase, A4h average erase, A6h later bad blocks.
// - attributes A8h PHY errors, C2h temperature, F1h sectors written.
module acsp_unit
	import acsp_pkg::*;
#(
	parameter logic DEVSLP_FITTED = 1'b1,
	parameter int unsigned SLUMBER_WAKE_CYC = `ACSP_SLUMBER_WAKE_CYC,
	parameter int unsigned DEVSLP_EXIT_CYC = `ACSP_DEVSLP_EXIT_CYC,
	parameter logic [19:0] AUTO_SLUMBER_CYC = 20'h0_0010,
	parameter logic [3:0] META_PROGS = 4'h4,
	parameter logic [15:0] BAD_LIMIT = 16'h0100
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_opcode,
	input wire logic [7:0] cmd_feature,
	input wire logic [7:0] cmd_count,
	output logic cmd_ready,
	output logic cmd_done,
	output logic [7:0] cmd_status,
	output logic [7:0] cmd_error,
	output logic [7:0] cmd_result,
	output logic rsp_valid,
	output logic [7:0] rsp_byte,
	output logic rsp_last,
	output logic ncq_read,
	output logic ncq_write,
	output logic erase_start,
	output logic offline_start,
	output logic trim_start,
	output logic autosave_on,
	output logic health_on,
	input wire logic host_lp_req,
	input wire logic host_lp_slumber,
	input wire logic host_wake,
	input wire logic dev_idle,
	input wire logic dipm_en,
	input wire logic auto_slumber_en,
	input wire logic devslp_pin,
	output logic [2:0] link_state,
	output logic phy_power_on,
	output logic dev_lp_req,
	input wire logic ecc_check,
	input wire logic [7:0] ecc_err_bits,
	output logic ecc_corrected,
	output logic ecc_failed,
	input wire logic bad_block_evt,
	output logic reloc_start,
	input wire logic power_fail_pin,
	input wire logic meta_prog_done,
	output logic meta_prog,
	input wire logic rebuild_done,
	output logic map_rebuild,
	input wire logic [31:0] raw_poh,
	input wire logic [31:0] raw_pcyc,
	input wire logic [15:0] raw_ers_max,
	input wire logic [15:0] raw_ers_avg,
	input wire logic [15:0] raw_phy_err,
	input wire logic [7:0] raw_temp,
	input wire logic [47:0] raw_sect_wr
);
	typedef struct packed {
		acsp_cmd_e cs;
		acsp_link_e ls;
		acsp_pmode_e pm;
		logic [19:0] cnt;
		logic [7:0] sub;
		logic [3:0] aidx;
		logic [3:0] bidx;
		logic thr;
		logic smart_en;
		logic autosave;
		logic armed;
		logic ready;
		logic done;
		logic [7:0] status;
		logic [7:0] error;
		logic [7:0] result;
		logic rsp_valid;
		logic [7:0] rsp_byte;
		logic rsp_last;
		logic ncq_rd;
		logic ncq_wr;
		logic erase_go;
		logic offline_go;
		logic trim_go;
		logic lp_req;
		logic [1:0] dslp_sync;
		logic [1:0] pf_sync;
		logic pf_seen;
		logic ecc_fix;
		logic ecc_fail;
		logic reloc_go;
		logic [3:0] meta_left;
		logic rebuild;
		logic [15:0] bad_cnt;
		logic [15:0] upl_cnt;
		logic phy_on, meta_busy;
	} acsp_state_s;

	acsp_state_s st_q, st_d;
	acsp_rec_if rec ();

	// opcodes this unit hands to the data path without further action
	function automatic logic acsp_known(input logic [7:0] op);
		unique case (op)
			8'h90, 8'hE7, 8'hEC, 8'hE3, 8'h91, 8'hC8, 8'h25, 8'h47, 8'h2F, 8'hC4, 8'h20, 8'h21,
			8'h40, 8'h41, 8'h10, 8'h57, 8'hC5, 8'hF6, 8'hF5, 8'hF1, 8'hF2, 8'hEF, 8'hC6, 8'hE6,
			8'hE2, 8'hCA, 8'h35, 8'h3F, 8'h30, 8'h31: acsp_known = 1'b1;
			default: acsp_known = (op[7:4] == 4'h7);
		endcase
	endfunction

	// raw value of each attribute slot, widened to seven bytes
	function automatic logic [55:0] acsp_raw(input logic [3:0] idx, input acsp_state_s s);
		unique case (idx)
			4'h0: acsp_raw = {24'h00_0000, raw_poh};
			4'h1: acsp_raw = {24'h00_0000, raw_pcyc};
			4'h2: acsp_raw = {40'h00_0000_0000, raw_ers_max};
			4'h3: acsp_raw = {40'h00_0000_0000, raw_ers_avg};
			4'h4: acsp_raw = {40'h00_0000_0000, s.bad_cnt};
			4'h5: acsp_raw = {40'h00_0000_0000, raw_phy_err};
			4'h6: acsp_raw = {40'h00_0000_0000, s.upl_cnt};
			4'h7: acsp_raw = {48'h0000_0000_0000, raw_temp};
			4'h8: acsp_raw = {8'h00, raw_sect_wr};
			default: acsp_raw = 56'h00_0000_0000_0000;
		endcase
	endfunction

	assign rec.attr_idx = st_q.aidx;
	assign rec.byte_idx = st_q.bidx;
	assign rec.thr_sel = st_q.thr;
	assign rec.raw = acsp_raw(st_q.aidx, st_q);

	acsp_rec_fmt #(
		.THRESHOLD(8'h00)
	) u_fmt (
		.rec(rec)
	);

	// next state: command decode, record streaming, link power, flash duties
	always_comb begin
		st_d = st_q;
		st_d.done = 1'b0;
		st_d.rsp_valid = 1'b0;
		st_d.rsp_last = 1'b0;
		st_d.ncq_rd = 1'b0;
		st_d.ncq_wr = 1'b0;
		st_d.erase_go = 1'b0;
		st_d.offline_go = 1'b0;
		st_d.trim_go = 1'b0;
		st_d.ecc_fix = 1'b0;
		st_d.ecc_fail = 1'b0;
		st_d.reloc_go = 1'b0;
		st_d.dslp_sync = {st_q.dslp_sync[0], devslp_pin};
		st_d.pf_sync = {st_q.pf_sync[0], power_fail_pin};
		// flash duties run regardless of link state
		if (ecc_check) begin
			st_d.ecc_fix = (ecc_err_bits <= `ACSP_ECC_MAX_BITS);
			st_d.ecc_fail = (ecc_err_bits > `ACSP_ECC_MAX_BITS);
		end
		if (bad_block_evt) begin
			st_d.reloc_go = 1'b1;
			st_d.bad_cnt = st_q.bad_cnt + 16'h0001;
		end
		// only the first rising edge of a loss counts; supply is not expected back
		if (st_q.pf_sync[1] && !st_q.pf_seen) begin
			st_d.pf_seen = 1'b1;
			st_d.meta_left = META_PROGS;
			st_d.upl_cnt = st_q.upl_cnt + 16'h0001;
		end else if (meta_prog_done && st_q.meta_left != 4'h0) begin
			st_d.meta_left = st_q.meta_left - 4'h1;
		end
		if (rebuild_done) begin
			st_d.rebuild = 1'b0;
		end
		st_d.lp_req = dipm_en && dev_idle && st_q.ls == ACSP_LS_ACTIVE && st_q.cs == ACSP_CS_IDLE;
		// link power sequencer
		unique case (st_q.ls)
			ACSP_LS_ACTIVE: begin
				if (host_lp_req && st_q.cs == ACSP_CS_IDLE) begin
					st_d.ls = host_lp_slumber ? ACSP_LS_SLUMBER : ACSP_LS_PARTIAL;
					st_d.cnt = AUTO_SLUMBER_CYC;
				end
			end
			ACSP_LS_PARTIAL: begin
				if (host_wake || cmd_valid) begin
					st_d.ls = ACSP_LS_WAKE;
					st_d.cnt = 20'(`ACSP_PARTIAL_WAKE_CYC - 1);
				end else if (auto_slumber_en) begin
					st_d.cnt = st_q.cnt - 20'h0_0001;
					if (st_q.cnt == 20'h0_0000) begin
						st_d.ls = ACSP_LS_SLUMBER;
					end
				end
			end
			ACSP_LS_SLUMBER: begin
				if (host_wake || cmd_valid) begin
					st_d.ls = ACSP_LS_WAKE;
					st_d.cnt = 20'(SLUMBER_WAKE_CYC - 1);
				end
			end
			ACSP_LS_DEVSLP: begin
				if (!st_q.dslp_sync[1]) begin
					st_d.ls = ACSP_LS_WAKE;
					st_d.cnt = 20'(DEVSLP_EXIT_CYC - 1);
				end
			end
			ACSP_LS_WAKE: begin
				st_d.cnt = st_q.cnt - 20'h0_0001;
				if (st_q.cnt == 20'h0_0000) begin
					st_d.ls = ACSP_LS_ACTIVE;
				end
			end
			default: st_d.ls = ACSP_LS_ACTIVE;
		endcase
		// sleep pin overrides other link states once the current command has ended
		if (DEVSLP_FITTED && st_q.dslp_sync[1] && st_q.cs == ACSP_CS_IDLE && st_q.ls != ACSP_LS_DEVSLP) begin
			st_d.ls = ACSP_LS_DEVSLP;
		end
		// command path
		unique case (st_q.cs)
			ACSP_CS_IDLE: begin
				if (cmd_valid && st_q.ready) begin
					st_d.ready = 1'b0;
					st_d.status = `ACSP_ST_OK;
					st_d.error = 8'h00;
					st_d.result = cmd_count;
					st_d.cs = ACSP_CS_DONE;
					st_d.sub = cmd_feature;
					unique case (cmd_opcode)
						`ACSP_OP_CHK_PWR: begin
							st_d.result = (st_q.pm == ACSP_PM_STB) ? `ACSP_PM_STBY :
								(st_q.pm == ACSP_PM_IDL) ? `ACSP_PM_IDLE : `ACSP_PM_ACTIVE;
						end
						`ACSP_OP_IDLE_IMM: st_d.pm = ACSP_PM_IDL;
						`ACSP_OP_STBY_IMM: st_d.pm = ACSP_PM_STB;
						`ACSP_OP_NCQ_RD: st_d.ncq_rd = 1'b1;
						`ACSP_OP_NCQ_WR: st_d.ncq_wr = 1'b1;
						`ACSP_OP_ERASE_PREP: st_d.armed = 1'b1;
						`ACSP_OP_TRIM: st_d.trim_go = 1'b1;
						`ACSP_OP_ERASE_UNIT: begin
							st_d.armed = 1'b0;
							st_d.erase_go = st_q.armed;
							st_d.status = st_q.armed ? `ACSP_ST_OK : `ACSP_ST_ERR;
							st_d.error = st_q.armed ? 8'h00 : `ACSP_ER_ABORT;
						end
						`ACSP_OP_HEALTH: begin
							// monitoring off refuses everything but re-enabling
							if (!st_q.smart_en && cmd_feature != `ACSP_SUB_ENABLE) begin
								st_d.status = `ACSP_ST_ERR;
								st_d.error = `ACSP_ER_ABORT;
							end else begin
								unique case (cmd_feature)
									`ACSP_SUB_RD_DATA, `ACSP_SUB_RD_THR: begin
										st_d.cs = ACSP_CS_STREAM;
										st_d.thr = (cmd_feature == `ACSP_SUB_RD_THR);
										st_d.aidx = 4'h0;
										st_d.bidx = 4'h0;
									end
									`ACSP_SUB_AUTOSAVE: st_d.autosave = (cmd_count == `ACSP_AUTOSAVE_ON);
									`ACSP_SUB_OFFLINE: st_d.offline_go = 1'b1;
									`ACSP_SUB_ENABLE: st_d.smart_en = 1'b1;
									`ACSP_SUB_DISABLE: st_d.smart_en = 1'b0;
									`ACSP_SUB_STATUS: st_d.result = {7'h00, st_q.bad_cnt >= BAD_LIMIT};
									default: begin
										st_d.status = `ACSP_ST_ERR;
										st_d.error = `ACSP_ER_ABORT;
									end
								endcase
							end
						end
						default: begin
							if (!acsp_known(cmd_opcode)) begin
								st_d.status = `ACSP_ST_ERR;
								st_d.error = `ACSP_ER_ABORT;
							end
						end
					endcase
				end
			end
			ACSP_CS_STREAM: begin
				// one record byte per cycle; formatter output is registered here
				st_d.rsp_valid = 1'b1;
				st_d.rsp_byte = rec.rec_byte;
				if (st_q.bidx == 4'(`ACSP_REC_BYTES - 1)) begin
					st_d.bidx = 4'h0;
					st_d.aidx = st_q.aidx + 4'h1;
					if (st_q.aidx == 4'(`ACSP_NUM_ATTR - 1)) begin
						st_d.rsp_last = 1'b1;
						st_d.cs = ACSP_CS_DONE;
					end
				end else begin
					st_d.bidx = st_q.bidx + 4'h1;
				end
			end
			ACSP_CS_DONE: begin
				st_d.done = 1'b1;
				st_d.cs = ACSP_CS_IDLE;
			end
			default: st_d.cs = ACSP_CS_IDLE;
		endcase
		st_d.ready = st_d.cs == ACSP_CS_IDLE && st_d.ls == ACSP_LS_ACTIVE && !st_d.rebuild && !st_d.pf_seen;
		st_d.phy_on = st_d.ls != ACSP_LS_DEVSLP;
		st_d.meta_busy = st_d.meta_left != 4'h0;
	end

	// single register of all state; rebuild starts armed at every power-up
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_q <= '0;
			st_q.cs <= ACSP_CS_IDLE;
			st_q.ls <= ACSP_LS_ACTIVE;
			st_q.smart_en <= 1'b1;
			st_q.phy_on <= 1'b1;
			st_q.rebuild <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign cmd_ready = st_q.ready;
	assign cmd_done = st_q.done;
	assign cmd_status = st_q.status;
	assign cmd_error = st_q.error;
	assign cmd_result = st_q.result;
	assign rsp_valid = st_q.rsp_valid;
	assign rsp_byte = st_q.rsp_byte;
	assign rsp_last = st_q.rsp_last;
	assign ncq_read = st_q.ncq_rd;
	assign ncq_write = st_q.ncq_wr;
	assign erase_start = st_q.erase_go;
	assign offline_start = st_q.offline_go;
	assign trim_start = st_q.trim_go;
	assign autosave_on = st_q.autosave;
	assign health_on = st_q.smart_en;
	assign link_state = st_q.ls;
	assign phy_power_on = st_q.phy_on;
	assign dev_lp_req = st_q.lp_req;
	assign ecc_corrected = st_q.ecc_fix;
	assign ecc_failed = st_q.ecc_fail;
	assign reloc_start = st_q.reloc_go;
	assign meta_prog = st_q.meta_busy;
	assign map_rebuild = st_q.rebuild;

	// checks on the design's own state and outputs
	a_partial_wake_time: assert property (@(posedge clk_sys) disable iff (reset)
		(st_q.ls == ACSP_LS_PARTIAL && st_d.ls == ACSP_LS_WAKE) |=> ##[1:499] st_q.ls == ACSP_LS_ACTIVE)
		else $error("partial wake too slow");
	a_slumber_load: assert property (@(posedge clk_sys) disable iff (reset)
		(st_q.ls == ACSP_LS_SLUMBER && st_d.ls == ACSP_LS_WAKE) |=> st_q.cnt == 20'(SLUMBER_WAKE_CYC - 1))
		else $error("slumber wake count wrong");
	a_devslp_load: assert property (@(posedge clk_sys) disable iff (reset)
		(st_q.ls == ACSP_LS_DEVSLP && !st_q.dslp_sync[1]) |=> st_q.cnt == 20'(DEVSLP_EXIT_CYC - 1))
		else $error("sleep exit count wrong");
	a_devslp_entry: assert property (@(posedge clk_sys) disable iff (reset)
		(DEVSLP_FITTED && st_q.dslp_sync[1] && st_q.cs == ACSP_CS_IDLE) |=> !phy_power_on)
		else $error("sleep pin ignored");
	a_auto_slumber: assert property (@(posedge clk_sys) disable iff (reset)
		(st_q.ls == ACSP_LS_PARTIAL && auto_slumber_en && !host_wake && !cmd_valid && st_q.cnt == 20'h0_0000
		&& !st_q.dslp_sync[1]) |=> st_q.ls == ACSP_LS_SLUMBER)
		else $error("auto slumber missed");
	a_ecc_limit: assert property (@(posedge clk_sys) disable iff (reset)
		ecc_check |=> (ecc_corrected == ($past(ecc_err_bits) <= 8'h48)) && (ecc_failed != ecc_corrected))
		else $error("ecc limit wrong");
	a_abort_unknown: assert property (@(posedge clk_sys) disable iff (reset)
		(cmd_valid && cmd_ready && !acsp_known(cmd_opcode) && cmd_opcode != 8'hB0 && cmd_opcode != 8'hE5
		&& cmd_opcode != 8'hE1 && cmd_opcode != 8'hE0 && cmd_opcode[7:1] != 7'h30 && cmd_opcode != 8'hF3
		&& cmd_opcode != 8'hF4 && cmd_opcode != 8'h06) |=> ##1 cmd_done && cmd_error == 8'h04 && !erase_start)
		else $error("unknown opcode not aborted");
	a_erase_needs_prep: assert property (@(posedge clk_sys) disable iff (reset)
		erase_start |-> $past(st_q.armed))
		else $error("erase without prepare");
	a_record_length: assert property (@(posedge clk_sys) disable iff (reset)
		(st_q.cs == ACSP_CS_IDLE && st_d.cs == ACSP_CS_STREAM) |=> ##108 rsp_last)
		else $error("record stream length wrong");
	a_meta_save: assert property (@(posedge clk_sys) disable iff (reset)
		(st_q.pf_sync[1] && !st_q.pf_seen) |=> meta_prog && !cmd_ready)
		else $error("metadata save not started");
	c_record_read: cover property (@(posedge clk_sys) disable iff (reset) rsp_last);
	c_devslp_exit: cover property (@(posedge clk_sys) disable iff (reset)
		st_q.ls == ACSP_LS_DEVSLP ##1 st_q.ls == ACSP_LS_WAKE);
	c_queued_read: cover property (@(posedge clk_sys) disable iff (reset) ncq_read);
endmodule

// File: acsp_unit_bench.sv
// self-checking bench of the command and power unit
`timescale 1ns/1ns
`include "acsp_consts.svh"
module acsp_unit_bench;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic cmd_valid, cmd_ready, cmd_done, rsp_valid, rsp_last, ncq_read, ncq_write, erase_start, offline_start;
	logic trim_start, autosave_on, health_on, host_lp_req, host_lp_slumber, host_wake, devslp_pin, phy_power_on;
	logic dev_lp_req, ecc_corrected, ecc_failed, reloc_start, meta_prog, map_rebuild;
	logic [7:0] cmd_opcode, cmd_feature, cmd_count, cmd_status, cmd_error, cmd_result, rsp_byte;
	logic [2:0] link_state;
	logic dev_idle = 1'b0, dipm_en = 1'b0, auto_slumber_en = 1'b0, ecc_check = 1'b0, bad_block_evt = 1'b0;
	logic power_fail_pin = 1'b0, meta_prog_done = 1'b0, rebuild_done = 1'b0;
	logic [7:0] ecc_err_bits = 8'h00, raw_temp = 8'h00;
	logic [31:0] raw_poh = '0, raw_pcyc = '0;
	logic [15:0] raw_ers_max = '0, raw_ers_avg = '0, raw_phy_err = '0;
	logic [47:0] raw_sect_wr = '0;
	int n_fail = 0, num_checks = 0, n;
	int pcnt [8] = '{default: 0};
	wire [7:0] pv = {ncq_read, ncq_write, erase_start, offline_start, trim_start, reloc_start, ecc_corrected, ecc_failed};
	acsp_unit #(.SLUMBER_WAKE_CYC(40), .DEVSLP_EXIT_CYC(60)) acsp_unit_inst (.*);
	acsp_host_model acsp_host_model_inst (.*);
	always #10 clk_sys = ~clk_sys;
	// pulse tally, index 7 is ncq_read down to 0 for ecc_failed
	always @(posedge clk_sys) begin
		for (int k = 0; k < 8; k++) pcnt[k] += int'(pv[k] === 1'b1);
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic ticks(input int c);
		repeat (c) @(posedge clk_sys);
	endtask
	// a hung handshake counts as a mismatch and ends the run
	task automatic cmd(input logic [7:0] op, input logic [7:0] ft, input logic [7:0] cn, input logic ok);
		acsp_host_model_inst.send(op, ft, cn);
		if (acsp_host_model_inst.tmo !== 1'b0) begin
			n_fail++;
			complete_run();
		end
		chk(cmd_status, ok ? `ACSP_ST_OK : `ACSP_ST_ERR);
		chk(cmd_error, ok ? 8'h00 : `ACSP_ER_ABORT);
	endtask
	task automatic smart(input logic [7:0] sub, input logic [7:0] cn, input logic ok);
		cmd(`ACSP_OP_HEALTH, sub, cn, ok);
	endtask
	task automatic wait_link(input logic [2:0] s, input int lim);
		for (n = 0; n < lim && link_state !== s; n++) @(posedge clk_sys);
		if (n >= lim) begin
			n_fail++;
			complete_run();
		end
	endtask
	// every byte of the nine records, threshold layout when thr is set
	task automatic check_recs(input logic thr);
		logic [55:0] raw [9];
		logic [7:0] id [9];
		logic [7:0] e;
		raw = '{56'(raw_poh), 56'(raw_pcyc), 56'(raw_ers_max), 56'(raw_ers_avg), 56'h0, 56'(raw_phy_err), 56'h0,
			56'(raw_temp), 56'(raw_sect_wr)};
		id = '{8'h09, 8'h0C, 8'hA3, 8'hA4, 8'hA6, 8'hA8, 8'hC0, 8'hC2, 8'hF1};
		chk(acsp_host_model_inst.n_rsp, 108);
		chk(acsp_host_model_inst.last_at, 107);
		for (int i = 0; i < 108; i++) begin
			case (i % 12)
				0: e = id[i / 12];
				1: e = thr ? 8'h00 : 8'(`ACSP_ATTR_FLAGS);
				3, 4: e = thr ? 8'h00 : `ACSP_ATTR_NORM;
				default: e = (thr || i % 12 < 5) ? 8'h00 : raw[i / 12][(i % 12 - 5) * 8 +: 8];
			endcase
			chk(acsp_host_model_inst.rsp_buf[i], e);
		end
	endtask
	task automatic t_boot();
		chk(map_rebuild, 1'b1);
		chk(cmd_ready, 1'b0);
		rebuild_done <= 1'b1;
		ticks(1);
		rebuild_done <= 1'b0;
		ticks(3);
		chk({map_rebuild, cmd_ready}, 2'b01);
		$display("boot done");
	endtask
	task automatic t_cmds();
		cmd(`ACSP_OP_CHK_PWR, 8'h00, 8'h00, 1'b1);
		chk(cmd_result, `ACSP_PM_ACTIVE);
		cmd(`ACSP_OP_IDLE_IMM, 8'h00, 8'h00, 1'b1);
		cmd(`ACSP_OP_CHK_PWR, 8'h00, 8'h00, 1'b1);
		chk(cmd_result, `ACSP_PM_IDLE);
		cmd(`ACSP_OP_STBY_IMM, 8'h00, 8'h00, 1'b1);
		cmd(`ACSP_OP_CHK_PWR, 8'h00, 8'h00, 1'b1);
		chk(cmd_result, `ACSP_PM_STBY);
		cmd(`ACSP_OP_NCQ_RD, 8'h00, 8'h08, 1'b1);
		cmd(`ACSP_OP_NCQ_WR, 8'h00, 8'h08, 1'b1);
		cmd(`ACSP_OP_ERASE_UNIT, 8'h00, 8'h00, 1'b0);
		cmd(`ACSP_OP_ERASE_PREP, 8'h00, 8'h00, 1'b1);
		cmd(`ACSP_OP_ERASE_UNIT, 8'h00, 8'h00, 1'b1);
		cmd(`ACSP_OP_TRIM, 8'h00, 8'h01, 1'b1);
		cmd(8'hFF, 8'h00, 8'h00, 1'b0);
		chk({8'(pcnt[7]), 8'(pcnt[6]), 8'(pcnt[5]), 8'(pcnt[3])}, 32'h0101_0101);
		$display("commands done");
	endtask
	task automatic t_health();
		{raw_poh, raw_pcyc} <= {32'h0102_0304, 32'hA5B6_C7D8};
		{raw_ers_max, raw_ers_avg, raw_phy_err, raw_temp} <= {16'h1357, 16'h2468, 16'hBEEF, 8'h2D};
		raw_sect_wr <= 48'h0A0B_0C0D_0E0F;
		smart(`ACSP_SUB_RD_DATA, 8'h00, 1'b1);
		check_recs(1'b0);
		smart(`ACSP_SUB_RD_THR, 8'h00, 1'b1);
		check_recs(1'b1);
		smart(`ACSP_SUB_STATUS, 8'h00, 1'b1);
		chk(cmd_result, 8'h00);
		smart(`ACSP_SUB_AUTOSAVE, `ACSP_AUTOSAVE_ON, 1'b1);
		chk(autosave_on, 1'b1);
		smart(`ACSP_SUB_AUTOSAVE, 8'h00, 1'b1);
		chk(autosave_on, 1'b0);
		smart(`ACSP_SUB_OFFLINE, 8'h00, 1'b1);
		chk(pcnt[4], 1);
		smart(8'hD7, 8'h00, 1'b0);
		smart(`ACSP_SUB_DISABLE, 8'h00, 1'b1);
		chk(health_on, 1'b0);
		smart(`ACSP_SUB_RD_DATA, 8'h00, 1'b0);
		smart(`ACSP_SUB_ENABLE, 8'h00, 1'b1);
		chk(health_on, 1'b1);
		$display("health done");
	endtask
	task automatic t_link();
		acsp_host_model_inst.req(1'b0, 1'b0);
		wait_link(3'h1, 5);
		acsp_host_model_inst.req(1'b1, 1'b0);
		wait_link(3'h0, 600);
		chk(n - 1 < 500, 1'b1);
		acsp_host_model_inst.req(1'b0, 1'b1);
		wait_link(3'h2, 5);
		acsp_host_model_inst.req(1'b1, 1'b0);
		wait_link(3'h0, 100);
		chk(n < 42, 1'b1);
		auto_slumber_en <= 1'b1;
		acsp_host_model_inst.req(1'b0, 1'b0);
		wait_link(3'h1, 5);
		wait_link(3'h2, 40);
		auto_slumber_en <= 1'b0;
		acsp_host_model_inst.req(1'b1, 1'b0);
		wait_link(3'h0, 100);
		{dipm_en, dev_idle} <= 2'b11;
		ticks(3);
		chk(dev_lp_req, 1'b1);
		{dipm_en, dev_idle} <= 2'b00;
		acsp_host_model_inst.req(1'b1, 1'b0);
		wait_link(3'h0, 600);
		acsp_host_model_inst.sleep_pin(1'b1);
		wait_link(3'h3, 10);
		chk(phy_power_on, 1'b0);
		acsp_host_model_inst.sleep_pin(1'b0);
		wait_link(3'h0, 100);
		chk(n - 1 < 64 && phy_power_on === 1'b1, 1'b1);
		$display("link done");
	endtask
	// back-to-back checks at the correction limit and one past it
	task automatic t_flash();
		{ecc_check, ecc_err_bits} <= {1'b1, `ACSP_ECC_MAX_BITS};
		ticks(1);
		ecc_err_bits <= `ACSP_ECC_MAX_BITS + 8'h01;
		ticks(1);
		{ecc_check, bad_block_evt} <= 2'b01;
		ticks(1);
		bad_block_evt <= 1'b0;
		power_fail_pin <= 1'b1;
		ticks(5);
		chk({8'(pcnt[2]), 8'(pcnt[1]), 8'(pcnt[0])}, 24'h01_0101);
		for (int k = 0; k < 4; k++) begin
			chk({meta_prog, cmd_ready}, 2'b10);
			meta_prog_done <= 1'b1;
			ticks(1);
			meta_prog_done <= 1'b0;
			ticks(2);
		end
		chk(meta_prog, 1'b0);
		{reset, power_fail_pin} <= 2'b10;
		ticks(10);
		reset <= 1'b0;
		ticks(2);
		t_boot();
		$display("flash done");
	endtask
	initial begin
		ticks(10);
		reset <= 1'b0;
		ticks(2);
		t_boot();
		t_cmds();
		t_health();
		t_link();
		t_flash();
		complete_run();
	end
endmodule
